/* inc/fsp_defines.svh */
// Function
// [R01] pointer is upper, high, low bytes concatenated
// [R02] low 21 bits program space, bit 21 config
// [R03] auto updates touch only low 21 bits
// [R04] pointer kept, post-inc, post-dec or pre-inc
// [R05] table read uses all 22 bits
// [R06] word array, pointer lsb picks byte
// [R07] table write fills holding register by bits 5:0
// [R08] program block chosen by pointer bits 21:6
// [R09] erase row chosen by bits 21:10
// [R10] erase unit is 1024 bytes only
// [R11] no bulk erase from own code
// [R12] software sets enable and erase select first
// [R13] keys 55h then AAh before start
// [R14] software loads pointer, masks interrupts, unlocks
// [R15] row erase stalls cpu about 2 ms
// [R16] long write halts cpu until timer ends
// [R17] program whole 64-byte blocks only
// [R18] table writes never touch flash array
// [R19] software starts program via control register
// [R20] holding registers kept after programming
// [R21] program each byte at most twice per erase
// [R22] start bit set only, cleared by hardware
// [R23] abort flag on reset mid-cycle or misuse
// [R24] key port reads as zero
// [R25] erase select cleared when erase completes
// [R26] start ignored unless both keys just preceded
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_REG_PTRU 3'h0
`define FSP_REG_PTRH 3'h1
`define FSP_REG_PTRL 3'h2
`define FSP_REG_LATCH 3'h3
`define FSP_REG_CTRL 3'h4
`define FSP_REG_KEY 3'h5
`define FSP_CTRL_ERASE 4
`define FSP_CTRL_ABORT 3
`define FSP_CTRL_PROGRAM_WRITE_ENABLE 2
`define FSP_CTRL_START 1
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'hAA
`define FSP_CLK_MHZ 40
`define FSP_LONG_WRITE_US 2000
`define FSP_LONG_WRITE_CYC (`FSP_LONG_WRITE_US * `FSP_CLK_MHZ)
`define FSP_ROW_BITS 10
`define FSP_BLK_BITS 6
`endif

/* inc/fsp_pkg.sv */
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_PTR_KEEP,
    FSP_PTR_POST_INC,
    FSP_PTR_POST_DEC,
    FSP_PTR_PRE_INC
  } fsp_ptr_mode_t;

  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_READ,
    FSP_LONG
  } fsp_state_t;

  typedef enum logic [1:0] {
    FSP_KEY_NONE,
    FSP_KEY_GOT1,
    FSP_KEY_GOT2
  } fsp_key_t;

  // cpu side register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } fsp_reg_req_t;

  // table instruction request
  typedef struct packed {
    logic rd;
    logic wr;
    fsp_ptr_mode_t mode;
  } fsp_tbl_req_t;

  // flash array port
  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic [20:0] waddr;
    logic cfg;
  } fsp_flash_cmd_t;

  typedef struct packed {
    logic [21:0] ptr;
    logic [7:0] latch;
    logic erase_sel;
    logic abort;
    logic program_write_enable;
    logic start;
    fsp_key_t key;
    fsp_state_t st;
    logic lsb;
    logic [31:0] cnt;
    logic [7:0] rdata;
    fsp_flash_cmd_t cmd;
  } fsp_state_vec_t;
endpackage : fsp_pkg

/* design/fsp_hold_mem.sv */
`timescale 1ns/1ps
// 64 byte holding buffer, registered read port
module fsp_hold_mem (
  input wire logic mclk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [5:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:63];

  // no reset: contents survive programming cycles
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata; // see [R07] [R20]
    end
    rdata <= mem[raddr];
  end
endmodule : fsp_hold_mem

/* design/fsp_table_access.sv */
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_table_access #(
  parameter int unsigned LONG_WRITE_CYC = `FSP_LONG_WRITE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input fsp_pkg::fsp_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input fsp_pkg::fsp_tbl_req_t tbl_req,
  output logic tbl_busy,
  output logic cpu_stall,
  output fsp_pkg::fsp_flash_cmd_t flash_cmd,
  input wire logic [15:0] flash_rword,
  input wire logic [5:0] hold_idx,
  output logic [7:0] hold_byte
);
  import fsp_pkg::*;

  fsp_state_vec_t s_ff;
  fsp_state_vec_t nxt_s;
  logic [21:0] ptr_pre;
  logic [21:0] ptr_use;
  logic hold_we;
  logic key_write;
  logic ctrl_write;
  logic start_req;
  logic [7:0] ctrl_rd;
  logic [5:0] hold_raddr;

  ////////////////////////////////////////////////////////////////////////
  // holding register storage
  assign hold_we = (s_ff.st == FSP_IDLE) && tbl_req.wr && !tbl_req.rd; // see [R18]
  assign hold_raddr = hold_idx;

  fsp_hold_mem u_hold (
    .mclk(mclk),
    .we(hold_we),
    .waddr(ptr_use[5:0]), // see [R07]
    .wdata(s_ff.latch),
    .raddr(hold_raddr),
    .rdata(hold_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // pointer arithmetic on low 21 bits only, bit 21 held
  always_comb begin
    ptr_pre = s_ff.ptr;
    if (tbl_req.mode == FSP_PTR_PRE_INC) begin
      ptr_pre = {s_ff.ptr[21], s_ff.ptr[20:0] + 21'h000001}; // see [R03] [R04]
    end
    ptr_use = ptr_pre;
  end

  assign key_write = reg_req.wr && (reg_req.addr == `FSP_REG_KEY);
  assign ctrl_write = reg_req.wr && (reg_req.addr == `FSP_REG_CTRL);
  // only a rising request for start counts; setting by write alone
  assign start_req = ctrl_write && reg_req.wdata[`FSP_CTRL_START] && !s_ff.start;

  ////////////////////////////////////////////////////////////////////////
  // control readback, unimplemented bits zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`FSP_CTRL_ERASE] = s_ff.erase_sel;
    ctrl_rd[`FSP_CTRL_ABORT] = s_ff.abort;
    ctrl_rd[`FSP_CTRL_PROGRAM_WRITE_ENABLE] = s_ff.program_write_enable;
    ctrl_rd[`FSP_CTRL_START] = s_ff.start;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.cmd.rd = 1'b0;
    nxt_s.cmd.erase = 1'b0;
    nxt_s.cmd.prog = 1'b0;
    // register reads, one cycle after strobe
    if (reg_req.rd) begin
      if (reg_req.addr == `FSP_REG_PTRU) begin
        nxt_s.rdata = {2'b00, s_ff.ptr[21:16]};
      end else if (reg_req.addr == `FSP_REG_PTRH) begin
        nxt_s.rdata = s_ff.ptr[15:8];
      end else if (reg_req.addr == `FSP_REG_PTRL) begin
        nxt_s.rdata = s_ff.ptr[7:0];
      end else if (reg_req.addr == `FSP_REG_LATCH) begin
        nxt_s.rdata = s_ff.latch;
      end else if (reg_req.addr == `FSP_REG_CTRL) begin
        nxt_s.rdata = ctrl_rd;
      end else begin
        nxt_s.rdata = 8'h00; // see [R24]
      end
    end
    case (s_ff.st)
      FSP_IDLE: begin
        // pointer registers, see [R01]
        if (reg_req.wr && reg_req.addr == `FSP_REG_PTRU) begin
          nxt_s.ptr[21:16] = reg_req.wdata[5:0];
        end
        if (reg_req.wr && reg_req.addr == `FSP_REG_PTRH) begin
          nxt_s.ptr[15:8] = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == `FSP_REG_PTRL) begin
          nxt_s.ptr[7:0] = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == `FSP_REG_LATCH) begin
          nxt_s.latch = reg_req.wdata;
        end
        // key sequence tracker
        if (key_write) begin
          if (reg_req.wdata == `FSP_KEY_FIRST) begin
            nxt_s.key = FSP_KEY_GOT1; // see [R13]
          end else if (reg_req.wdata == `FSP_KEY_SECOND && s_ff.key == FSP_KEY_GOT1) begin
            nxt_s.key = FSP_KEY_GOT2;
          end else begin
            nxt_s.key = FSP_KEY_NONE; // see [R26]
          end
        end else if (reg_req.wr && !ctrl_write) begin
          nxt_s.key = FSP_KEY_NONE; // see [R26]
        end
        if (ctrl_write) begin
          nxt_s.erase_sel = reg_req.wdata[`FSP_CTRL_ERASE];
          nxt_s.program_write_enable = reg_req.wdata[`FSP_CTRL_PROGRAM_WRITE_ENABLE];
          // software may clear the abort flag, not set it
          if (!reg_req.wdata[`FSP_CTRL_ABORT]) begin
            nxt_s.abort = 1'b0;
          end
          nxt_s.key = FSP_KEY_NONE;
          if (start_req) begin
            if (s_ff.key == FSP_KEY_GOT2 && reg_req.wdata[`FSP_CTRL_PROGRAM_WRITE_ENABLE]) begin
              // launch long write, see [R13] [R19] [R22]
              nxt_s.start = 1'b1;
              nxt_s.st = FSP_LONG;
              nxt_s.cnt = 32'(LONG_WRITE_CYC - 1);
              // bit 21 selects config space either way, see [R02]
              nxt_s.cmd.cfg = s_ff.ptr[21];
              if (reg_req.wdata[`FSP_CTRL_ERASE]) begin
                // row only, never bulk, see [R09] [R10] [R11]
                nxt_s.cmd.erase = 1'b1;
                nxt_s.cmd.waddr = {s_ff.ptr[20:`FSP_ROW_BITS], 10'h000} >> 1;
              end else begin
                // whole block of 32 words, see [R08] [R17]
                nxt_s.cmd.prog = 1'b1;
                nxt_s.cmd.waddr = {s_ff.ptr[20:`FSP_BLK_BITS], 6'h00} >> 1;
              end
            end else begin
              nxt_s.abort = 1'b1; // see [R23]
            end
          end
        end
        // table instructions
        if (tbl_req.rd) begin
          // word address from all 22 bits, see [R05]
          nxt_s.cmd.rd = 1'b1;
          nxt_s.cmd.cfg = ptr_use[21];
          nxt_s.cmd.waddr = ptr_use[21:1];
          nxt_s.lsb = ptr_use[0];
          nxt_s.st = FSP_READ;
        end
        if (tbl_req.rd || tbl_req.wr) begin
          case (tbl_req.mode)
            FSP_PTR_POST_INC: begin
              nxt_s.ptr = {ptr_use[21], ptr_use[20:0] + 21'h000001}; // see [R03] [R04]
            end
            FSP_PTR_POST_DEC: begin
              nxt_s.ptr = {ptr_use[21], ptr_use[20:0] - 21'h000001}; // see [R03] [R04]
            end
            default: begin
              nxt_s.ptr = ptr_use; // see [R04]
            end
          endcase
        end
      end
      FSP_READ: begin
        // lsb picks high or low byte of the word, see [R06]
        nxt_s.latch = s_ff.lsb ? flash_rword[15:8] : flash_rword[7:0];
        nxt_s.st = FSP_IDLE;
      end
      FSP_LONG: begin
        // cpu held until timer expiry, see [R15] [R16]
        if (s_ff.cnt == 32'h00000000) begin
          nxt_s.st = FSP_IDLE;
          nxt_s.start = 1'b0; // see [R22]
          nxt_s.erase_sel = 1'b0; // see [R25]
        end else begin
          nxt_s.cnt = s_ff.cnt - 32'h00000001;
        end
      end
      default: begin
        nxt_s.st = FSP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; abort stays set by reset so a cut cycle shows
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '0;
      s_ff.abort <= 1'b1; // see [R23]
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata = s_ff.rdata;
  assign flash_cmd = s_ff.cmd;
  assign cpu_stall = (s_ff.st == FSP_LONG); // see [R16]
  assign tbl_busy = (s_ff.st != FSP_IDLE);
endmodule : fsp_table_access

/* sim/fsp_flash_model.sv */
`timescale 1ns/1ps
// flash array stand-in: each word is built from its own address
module fsp_flash_model (
  mclk,
  flash_cmd,
  flash_rword
);
  import fsp_pkg::*;
  input wire logic mclk;
  input fsp_pkg::fsp_flash_cmd_t flash_cmd;
  output logic [15:0] flash_rword;
  logic [15:0] idle_ff = 16'h0000;
  // toggles outside the read slot so a late sample cannot match by luck
  always @(posedge mclk) idle_ff <= ~idle_ff;
  // word stands while the read pulse does, so the edge that ends the pulse takes it
  assign flash_rword = (flash_cmd.rd === 1'b1) ?
    {~flash_cmd.waddr[7:0], flash_cmd.waddr[7:0]} : idle_ff;
endmodule : fsp_flash_model

/* sim/fsp_table_access_asserts.sv */
`timescale 1ns/1ps
module fsp_table_access_asserts #(
  parameter int unsigned LONG_WRITE_CYC = 8
) (
  input logic mclk,
  input logic resetn,
  input fsp_pkg::fsp_reg_req_t reg_req,
  input logic [7:0] reg_rdata,
  input fsp_pkg::fsp_tbl_req_t tbl_req,
  input logic tbl_busy,
  input logic cpu_stall,
  input fsp_pkg::fsp_flash_cmd_t flash_cmd,
  input logic [15:0] flash_rword,
  input logic [5:0] hold_idx,
  input logic [7:0] hold_byte
);
  import fsp_pkg::*;
  logic [31:0] run_ff;
  logic [1:0] key_ff;
  logic go_now;
  // stall run length and unlock progress, tracked beside the design
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_ff <= 32'h0;
      key_ff <= 2'h0;
    end else begin
      run_ff <= cpu_stall ? run_ff + 32'h1 : 32'h0;
      if (reg_req.wr) key_ff <= (reg_req.addr == 3'h5 && reg_req.wdata == 8'h55) ? 2'h1 :
        (reg_req.addr == 3'h5 && reg_req.wdata == 8'hAA && key_ff == 2'h1) ? 2'h2 : 2'h0;
    end
  end
  // start write that the unlock keys allow, taken only while idle
  assign go_now = reg_req.wr && reg_req.addr == 3'h4 && reg_req.wdata[2:1] == 2'h3 &&
    key_ff == 2'h2 && !tbl_busy;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_read;
    flash_cmd.rd ##1 !tbl_busy;
  endsequence
  sequence s_go;
    go_now;
  endsequence
  property p_stall_len;
    $fell(cpu_stall) |-> run_ff == LONG_WRITE_CYC;
  endproperty
  property p_erase_row;
    flash_cmd.erase |-> flash_cmd.waddr[8:0] == 9'h000 && cpu_stall;
  endproperty
  property p_prog_block;
    flash_cmd.prog |-> flash_cmd.waddr[4:0] == 5'h00 && cpu_stall;
  endproperty
  property p_unlock;
    (flash_cmd.prog || flash_cmd.erase) |-> $past(go_now);
  endproperty
  property p_go_stall;
    s_go |=> cpu_stall && (flash_cmd.prog != flash_cmd.erase);
  endproperty
  property p_key_zero;
    reg_req.rd && reg_req.addr == 3'h5 |=> reg_rdata == 8'h00;
  endproperty
  property p_table_read;
    tbl_req.rd && !tbl_busy |=> s_read;
  endproperty
  property p_start_seen;
    cpu_stall && reg_req.rd && reg_req.addr == 3'h4 |=> reg_rdata[1];
  endproperty
  property p_short_write;
    tbl_req.wr && !tbl_busy |=> !flash_cmd.prog && !flash_cmd.erase && !cpu_stall;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length off");
  a_erase_row: assert property (p_erase_row) else $error("erase not row based");
  a_prog_block: assert property (p_prog_block) else $error("program not block");
  a_unlock: assert property (p_unlock) else $error("long write without unlock");
  a_go_stall: assert property (p_go_stall) else $error("unlocked start ignored");
  a_key_zero: assert property (p_key_zero) else $error("key port not zero");
  a_table_read: assert property (p_table_read) else $error("table read timing");
  a_start_seen: assert property (p_start_seen) else $error("start bit low in stall");
  a_short_write: assert property (p_short_write) else $error("table write hit array");
endmodule : fsp_table_access_asserts
////////////////////////////////////////////////////////////////////////////////
bind fsp_table_access fsp_table_access_asserts #(.LONG_WRITE_CYC(LONG_WRITE_CYC)) chk (
  .mclk(mclk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .tbl_req(tbl_req), .tbl_busy(tbl_busy), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd),
  .flash_rword(flash_rword), .hold_idx(hold_idx), .hold_byte(hold_byte));

/* sim/fsp_table_access_tb.sv */
`timescale 1ns/1ps
module fsp_table_access_tb;
  import fsp_pkg::*;
  localparam int unsigned LW = 8;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  fsp_reg_req_t rq = '0;
  fsp_tbl_req_t tq = '0;
  logic [7:0] rdat;
  logic busy;
  logic stall;
  fsp_flash_cmd_t fc;
  logic [15:0] rword;
  logic [5:0] hidx = 6'h00;
  logic [7:0] hbyte;
  int fail_count = 0;
  int samples_checked = 0;
  // short long-write count keeps the run brief
  always #12.5 mclk = ~mclk;
  fsp_table_access #(.LONG_WRITE_CYC(LW)) dut (.mclk(mclk), .resetn(resetn), .reg_req(rq),
    .reg_rdata(rdat), .tbl_req(tq), .tbl_busy(busy), .cpu_stall(stall), .flash_cmd(fc),
    .flash_rword(rword), .hold_idx(hidx), .hold_byte(hbyte));
  fsp_flash_model flash (.mclk(mclk), .flash_cmd(fc), .flash_rword(rword));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // one idle cycle before each strobe, so no signal is set twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    rq <= '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    rq <= '0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge mclk);
    rq <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    rq <= '0;
    chk(rdat, e);
  endtask : rd
  task automatic top(input logic r, input fsp_ptr_mode_t m);
    @(negedge mclk);
    tq <= '{r, ~r, m};
    @(negedge mclk);
    tq <= '0;
    chk(busy, r);
    repeat (2) @(negedge mclk);
  endtask : top
  // unlock keys, control write, then watch the stall and the control bits
  task automatic lw(input logic [7:0] k, input logic [7:0] c, input logic go);
    int n;
    n = 0;
    wr(3'h5, 8'h55);
    wr(3'h5, k);
    wr(3'h4, c);
    // the stall begins at the edge that takes the start write, so count this cycle too
    if (stall === 1'b1) n++;
    for (int i = 0; i < LW + 6; i++) begin
      @(negedge mclk);
      if (i == 1) rq <= '{1'b0, 1'b1, 3'h4, 8'h00};
      else rq <= '0;
      if (i == 3) chk(rdat, go ? c : (c & 8'hFD) | 8'h08);
      if (stall === 1'b1) n++;
    end
    chk(n, go ? LW : 0);
    rd(3'h4, go ? c & 8'hE4 : (c & 8'hFD) | 8'h08);
  endtask : lw
  task automatic final_report();
    $display("counts: %0d compared, %0d mismatched", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [21:0] p;
    repeat (2) @(negedge mclk);
    resetn <= 1'b1;
    rd(3'h4, 8'h08);
    rd(3'h5, 8'h00);
    $display("test reset done");
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h23);
    wr(3'h2, 8'h45);
    p = 22'h012345;
    for (int m = 0; m < 4; m++) begin
      if (m == 3) p[20:0] = p[20:0] + 21'h1;
      top(1'b1, fsp_ptr_mode_t'(m));
      chk(fc.waddr, p[21:1]);
      rd(3'h3, p[0] ? ~p[8:1] : p[8:1]);
      if (m == 1) p[20:0] = p[20:0] + 21'h1;
      if (m == 2) p[20:0] = p[20:0] - 21'h1;
      rd(3'h2, p[7:0]);
    end
    wr(3'h0, 8'h3F);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'hFF);
    top(1'b1, FSP_PTR_POST_INC);
    chk(fc.cfg, 1'b1);
    rd(3'h0, 8'h20);
    rd(3'h2, 8'h00);
    $display("test table read done");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h04);
    wr(3'h2, 8'hC5);
    wr(3'h3, 8'hAB);
    top(1'b0, FSP_PTR_KEEP);
    hidx <= 6'h05;
    repeat (2) @(negedge mclk);
    chk(hbyte, 8'hAB);
    $display("test table write done");
    wr(3'h4, 8'h04);
    lw(8'hAA, 8'h06, 1'b1);
    chk(fc.waddr, 21'h000260);
    chk(hbyte, 8'hAB);
    lw(8'hAA, 8'h16, 1'b1);
    chk(fc.waddr, 21'h000200);
    $display("test long write done");
    lw(8'h55, 8'h06, 1'b0);
    lw(8'hAA, 8'h02, 1'b0);
    $display("test refusal done");
    final_report();
  end
endmodule : fsp_table_access_tb
